// >>> rtu_defs.svh
// register map, field positions, reset values and axi response codes for the rs485 uart
// ****************************************************************
// What this block does
// - modem control bit drives the rs485 driver transmit-drive control output.
// - a byte written to the data location is queued for serial transmission.
// - line status bits 5 and 6 both read zero once holding and shift drain.
// - reception works like ordinary rs232 reception, no direction action needed.
// ****************************************************************
`ifndef RTU_DEFS_SVH
`define RTU_DEFS_SVH

// register indices, byte address is the index times four
`define RTU_IDX_DATA       3'h0
`define RTU_IDX_MODEM      3'h4
`define RTU_IDX_LSR        3'h5
`define RTU_IDX_ISTAT      3'h6
`define RTU_IDX_IMASK      3'h7
`define RTU_IDX_DIV        3'h3

// field positions
`define RTU_MCR_DRIVE      0
`define RTU_LSR_RXREADY    0
`define RTU_LSR_OVERRUN    1
`define RTU_LSR_FRAMING    3
`define RTU_LSR_HOLD_EMPTY 5
`define RTU_LSR_SHIFT_EMPTY 6
`define RTU_INT_RX         0
`define RTU_INT_TXEMPTY    1
`define RTU_INT_ERROR      2

// reset values
`define RTU_MCR_RESET      8'h00
`define RTU_IMASK_RESET    8'h00
`define RTU_DIV_RESET      16'h006c

// axi responses
`define RTU_RESP_OKAY      2'b00
`define RTU_RESP_SLVERR    2'b10

`endif

// >>> rtu_pkg.sv
// types shared by the rs485 uart modules
package rtu_pkg;
	typedef enum logic [1:0] {
		RTU_IDLE  = 2'b00,
		RTU_START = 2'b01,
		RTU_DATA  = 2'b10,
		RTU_STOP  = 2'b11
	} rtu_ser_st_t;
endpackage

// >>> rtu_tx.sv
// serial transmitter: holding register plus shift register
`timescale 1ns/100ps
`include "rtu_defs.svh"
module rtu_tx
	import rtu_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// baud tick, sixteen per bit
	input  wire logic       tick16,
	// byte load from register file
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	// status and line
	output logic            hold_empty,
	output logic            shift_empty,
	output logic            txd
);
	typedef struct packed {
		rtu_ser_st_t st;
		logic [7:0]  hold;
		logic        hold_full;
		logic [7:0]  shift;
		logic [3:0]  sub;
		logic [2:0]  bitn;
		logic        line;
	} rtu_tx_st_t;

	rtu_tx_st_t s_ff;
	rtu_tx_st_t nxt_s;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		nxt_s = s_ff;
		if (load) begin
			nxt_s.hold      = load_data;
			nxt_s.hold_full = 1'b1;
		end
		case (s_ff.st)
			RTU_IDLE: begin
				nxt_s.line = 1'b1;
				if (s_ff.hold_full) begin
					nxt_s.shift     = s_ff.hold;
					nxt_s.hold_full = load;  // new load wins over the move
					nxt_s.st        = RTU_START;
					nxt_s.sub       = 4'h0;
					nxt_s.line      = 1'b0;
				end
			end
			RTU_START, RTU_DATA, RTU_STOP: begin
				if (tick16) begin
					nxt_s.sub = s_ff.sub + 4'h1;
					if (s_ff.sub == 4'hf) begin
						case (s_ff.st)
							RTU_START: begin
								nxt_s.st   = RTU_DATA;
								nxt_s.bitn = 3'h0;
								nxt_s.line = s_ff.shift[0];
							end
							RTU_DATA: begin
								nxt_s.shift = {1'b0, s_ff.shift[7:1]};
								nxt_s.bitn  = s_ff.bitn + 3'h1;
								if (s_ff.bitn == 3'h7) begin
									nxt_s.st   = RTU_STOP;
									nxt_s.line = 1'b1;
								end else begin
									nxt_s.line = s_ff.shift[1];
								end
							end
							default: nxt_s.st = RTU_IDLE;
						endcase
					end
				end
			end
			default: nxt_s.st = RTU_IDLE;
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '{st: RTU_IDLE, hold: 8'h00, hold_full: 1'b0, shift: 8'h00,
				sub: 4'h0, bitn: 3'h0, line: 1'b1};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// status flags, both high when fully drained
	assign hold_empty  = !s_ff.hold_full;
	assign shift_empty = (s_ff.st == RTU_IDLE) && !s_ff.hold_full;
	assign txd         = s_ff.line;
endmodule // rtu_tx

// >>> rtu_rx.sv
// serial receiver with sixteen-times oversampling
`timescale 1ns/100ps
`include "rtu_defs.svh"
module rtu_rx
	import rtu_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// baud tick and synchronised line
	input  wire logic       tick16,
	input  wire logic       rxd_sync,
	// received byte, one-cycle strobe
	output logic            done,
	output logic            frame_err,
	output logic [7:0]      data
);
	typedef struct packed {
		rtu_ser_st_t st;
		logic [3:0]  sub;
		logic [2:0]  bitn;
		logic [7:0]  sh;
		logic        done;
		logic        ferr;
	} rtu_rx_st_t;

	rtu_rx_st_t s_ff;
	rtu_rx_st_t nxt_s;

	// ****************************************************************
	// next state: sample mid-bit
	// ****************************************************************
	always_comb begin
		nxt_s      = s_ff;
		nxt_s.done = 1'b0;
		case (s_ff.st)
			RTU_IDLE: begin
				if (!rxd_sync) begin
					nxt_s.st  = RTU_START;
					nxt_s.sub = 4'h0;
				end
			end
			default: begin
				if (tick16) begin
					nxt_s.sub = s_ff.sub + 4'h1;
					if (s_ff.st == RTU_START && s_ff.sub == 4'h7) begin
						nxt_s.sub  = 4'h0;
						nxt_s.bitn = 3'h0;
						nxt_s.st   = rxd_sync ? RTU_IDLE : RTU_DATA;  // glitch reject
					end else if (s_ff.sub == 4'hf) begin
						if (s_ff.st == RTU_DATA) begin
							nxt_s.sh   = {rxd_sync, s_ff.sh[7:1]};
							nxt_s.bitn = s_ff.bitn + 3'h1;
							if (s_ff.bitn == 3'h7) begin
								nxt_s.st = RTU_STOP;
							end
						end else begin
							nxt_s.st   = RTU_IDLE;
							nxt_s.done = 1'b1;
							nxt_s.ferr = !rxd_sync;
						end
					end
				end
			end
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '{st: RTU_IDLE, sub: 4'h0, bitn: 3'h0, sh: 8'h00,
				done: 1'b0, ferr: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign done      = s_ff.done;
	assign frame_err = s_ff.ferr;
	assign data      = s_ff.sh;
endmodule // rtu_rx

// >>> rtu_top.sv
// rs485 uart top: axi4-lite register file, baud divider, direction control
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "rtu_defs.svh"
module rtu_top
	import rtu_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,

	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [4:0]  s_axi_awaddr,

	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,

	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,

	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [4:0]  s_axi_araddr,

	// axi4-lite read data
	input  wire logic        s_axi_rvalid_unused_tie,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,

	// serial line and transceiver
	output logic             txd,
	input  wire logic        rxd,
	output logic             transmit_drive_control,

	// interrupt
	output logic             irq
);
	typedef struct packed {
		// write address and data held until the response
		logic        aw_got;
		logic [2:0]  aw_idx;
		logic        aw_bad;
		logic        w_got;
		logic [7:0]  w_data;
		logic        w_en;
		// write response
		logic        bvalid;
		logic [1:0]  bresp;
		// read response
		logic        rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
		// software registers
		logic [7:0]  mcr;
		logic [15:0] div;
		// baud divider count
		logic [15:0] cnt;
		// receive side
		logic [7:0]  rbuf;
		logic        rx_ready;
		logic        overrun;
		logic        framing;
		// interrupt state
		logic [2:0]  istat;
		logic [2:0]  imask;
		// drained edge memory and line synchroniser
		logic        txe_prev;
		logic [1:0]  rxs;
	} rtu_top_st_t;

	rtu_top_st_t s_ff;
	rtu_top_st_t nxt_s;
	// engine handshakes and status
	logic        tick16;
	logic        tx_load;
	logic        hold_empty;
	logic        shift_empty;
	logic        rx_done;
	logic        rx_ferr;
	logic [7:0]  rx_data;
	// bus decode
	logic        wr_fire;
	logic        rd_fire;
	logic [2:0]  ar_idx;
	logic        ar_bad;
	// line status word
	logic [7:0]  lsr;
	logic        tx_drained;

	// register map, one word per index, data in bits 7:0
	// index 0: data, write queues a byte, read takes the received byte
	// index 3: divider low byte, tick16 every divider plus one cycles
	// index 4: modem control, bit 0 drives the transceiver
	// index 5: line status, read only, bits 5 and 6 read zero once drained
	// index 6: interrupt status, write one to clear
	// index 7: interrupt mask, same layout as the status
	// indices 1 and 2 and misaligned addresses answer slverr

	// ****************************************************************
	// decode and status
	// ****************************************************************
	// divider wrap and read address decode
	assign tick16     = (s_ff.cnt == 16'h0000);
	assign ar_idx     = s_axi_araddr[4:2];
	assign ar_bad     = (s_axi_araddr[1:0] != 2'h0) || (ar_idx == 3'h1) || (ar_idx == 3'h2);
	// a write fires once both halves are held and no response waits
	assign wr_fire    = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
	assign rd_fire    = s_axi_arvalid && !s_ff.rvalid;
	assign tx_load    = wr_fire && !s_ff.aw_bad && s_ff.w_en && (s_ff.aw_idx == `RTU_IDX_DATA);
	assign tx_drained = hold_empty && shift_empty;

	// line status word, holding and shift bits read zero once drained
	always_comb begin
		lsr                        = 8'h00;
		lsr[`RTU_LSR_RXREADY]      = s_ff.rx_ready;
		lsr[`RTU_LSR_OVERRUN]      = s_ff.overrun;
		lsr[`RTU_LSR_FRAMING]      = s_ff.framing;
		lsr[`RTU_LSR_HOLD_EMPTY]   = !hold_empty;
		lsr[`RTU_LSR_SHIFT_EMPTY]  = !shift_empty;
	end

	// ****************************************************************
	// next state: bus, registers, divider, events
	// ****************************************************************
	always_comb begin
		nxt_s     = s_ff;
		nxt_s.rxs = {s_ff.rxs[0], rxd};

		// baud divider, one tick16 pulse per wrap
		nxt_s.cnt = tick16 ? s_ff.div : (s_ff.cnt - 16'h0001);

		// address and data taken in either order
		if (s_axi_awvalid && !s_ff.aw_got) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.aw_idx = s_axi_awaddr[4:2];
			nxt_s.aw_bad = (s_axi_awaddr[1:0] != 2'h0) || (s_axi_awaddr[4:2] == 3'h1)
				|| (s_axi_awaddr[4:2] == 3'h2) || (s_axi_awaddr[4:2] == `RTU_IDX_LSR);
		end
		if (s_axi_wvalid && !s_ff.w_got) begin
			nxt_s.w_got  = 1'b1;
			nxt_s.w_data = s_axi_wdata[7:0];
			nxt_s.w_en   = s_axi_wstrb[0];
		end

		// events: set wins over clear
		nxt_s.txe_prev = tx_drained;
		if (wr_fire) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got  = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp  = s_ff.aw_bad ? `RTU_RESP_SLVERR : `RTU_RESP_OKAY;
			if (!s_ff.aw_bad && s_ff.w_en) begin
				case (s_ff.aw_idx)
					`RTU_IDX_MODEM: nxt_s.mcr = s_ff.w_data;
					`RTU_IDX_DIV: nxt_s.div = {8'h00, s_ff.w_data};
					`RTU_IDX_ISTAT: nxt_s.istat = s_ff.istat & ~s_ff.w_data[2:0];
					`RTU_IDX_IMASK: nxt_s.imask = s_ff.w_data[2:0];
					default: nxt_s.div = s_ff.div;
				endcase
			end
		end

		// response taken by the master
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end

		// read path, one cycle after arvalid
		if (rd_fire) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp  = ar_bad ? `RTU_RESP_SLVERR : `RTU_RESP_OKAY;
			case (ar_idx)
				`RTU_IDX_DATA: begin
					nxt_s.rdata    = s_ff.rbuf;
					nxt_s.rx_ready = 1'b0;
				end
				`RTU_IDX_MODEM: nxt_s.rdata = s_ff.mcr;
				`RTU_IDX_LSR: begin
					nxt_s.rdata   = lsr;
					nxt_s.overrun = 1'b0;
					nxt_s.framing = 1'b0;
				end
				`RTU_IDX_DIV: nxt_s.rdata = s_ff.div[7:0];
				`RTU_IDX_ISTAT: nxt_s.rdata = {5'h00, s_ff.istat};
				`RTU_IDX_IMASK: nxt_s.rdata = {5'h00, s_ff.imask};
				default: nxt_s.rdata = 8'h00;
			endcase
		end

		// read data taken by the master
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end

		// receiver capture, ordinary uart behaviour, error flags stay until read
		if (rx_done) begin
			nxt_s.rbuf     = rx_data;
			nxt_s.rx_ready = 1'b1;
			nxt_s.istat[`RTU_INT_RX] = 1'b1;
			// unread byte overwritten
			if (s_ff.rx_ready && !(rd_fire && ar_idx == `RTU_IDX_DATA)) begin
				nxt_s.overrun = 1'b1;
			end
			if (rx_ferr) begin
				nxt_s.framing               = 1'b1;
				nxt_s.istat[`RTU_INT_ERROR] = 1'b1;
			end
		end

		// transmitter drained edge
		if (tx_drained && !s_ff.txe_prev) begin
			nxt_s.istat[`RTU_INT_TXEMPTY] = 1'b1;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// idle: readies high, line high, drive released
			s_ff <= '{
				aw_got:   1'b0,
				aw_idx:   3'h0,
				aw_bad:   1'b0,
				w_got:    1'b0,
				w_data:   8'h00,
				w_en:     1'b0,
				bvalid:   1'b0,
				bresp:    2'h0,
				rvalid:   1'b0,
				rdata:    8'h00,
				rresp:    2'h0,
				mcr:      `RTU_MCR_RESET,
				div:      `RTU_DIV_RESET,
				cnt:      16'h0000,
				rbuf:     8'h00,
				rx_ready: 1'b0,
				overrun:  1'b0,
				framing:  1'b0,
				istat:    3'h0,
				imask:    3'h0,
				txe_prev: 1'b1,
				rxs:      2'h3
			};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ****************************************************************
	// serial engines
	// ****************************************************************
	// transmitter, loads from the held write data
	rtu_tx u_tx (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.tick16      (tick16),
		.load        (tx_load),
		.load_data   (s_ff.w_data),
		.hold_empty  (hold_empty),
		.shift_empty (shift_empty),
		.txd         (txd)
	);

	// receiver on the synchronised line
	rtu_rx u_rx (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.tick16    (tick16),
		.rxd_sync  (s_ff.rxs[1]),
		.done      (rx_done),
		.frame_err (rx_ferr),
		.data      (rx_data)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	// write channel handshakes
	assign s_axi_awready          = !s_ff.aw_got;
	assign s_axi_wready           = !s_ff.w_got;
	assign s_axi_bvalid           = s_ff.bvalid;
	assign s_axi_bresp            = s_ff.bresp;

	// read channel, upper bytes read zero
	assign s_axi_arready          = !s_ff.rvalid;
	assign s_axi_rvalid           = s_ff.rvalid;
	assign s_axi_rdata            = {24'h000000, s_ff.rdata};
	assign s_axi_rresp            = s_ff.rresp;

	// transceiver direction and interrupt level
	assign transmit_drive_control = s_ff.mcr[`RTU_MCR_DRIVE];
	assign irq                    = |(s_ff.istat & s_ff.imask);
endmodule // rtu_top

// >>> rtu_top_checker.sv
// concurrent checks on the rs485 uart top ports
`timescale 1ns/100ps
`include "rtu_defs.svh"
module rtu_top_checker (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [4:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	// line side
	input wire logic        txd,
	input wire logic        transmit_drive_control,
	input wire logic        irq
);
	// ****************************************************************
	// properties
	// ****************************************************************
	logic [9:0] idle_cnt_ff;
	logic       wr_take;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles the line has stayed high, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn || !txd)
			idle_cnt_ff <= 10'h000;
		else if (idle_cnt_ff != 10'h3ff)
			idle_cnt_ff <= idle_cnt_ff + 10'h001;
	end
	assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	a_drive_reset: assert property ($rose(aresetn) |-> !transmit_drive_control && txd)
		else $error("drive or line not idle after reset");
	a_drive_cause: assert property ($changed(transmit_drive_control) |->
		!$past(s_axi_awready) || ($past(s_axi_awvalid) && $past(s_axi_awready)))
		else $error("drive control moved without a write");
	a_tx_start: assert property (wr_take && idle_cnt_ff == 10'h3ff &&
		s_axi_awaddr == {`RTU_IDX_DATA, 2'h0} |-> ##[1:64] !txd)
		else $error("queued byte did not start");
	a_bit_min_len: assert property ($fell(txd) |-> !txd [*8])
		else $error("serial bit too short");
	a_write_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_write_refused: assert property (!s_axi_awready && !s_axi_wready && !s_axi_bvalid |=>
		s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("held write not answered in one cycle");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	// main scenarios seen
	c_write: cover property (wr_take);
	c_drive_on: cover property ($rose(transmit_drive_control));
	c_irq: cover property ($rose(irq));
endmodule // rtu_top_checker

bind rtu_top rtu_top_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .txd, .transmit_drive_control, .irq);

// >>> rtu_node.sv
// rs485 transceiver and remote node model
`timescale 1ns/100ps
module rtu_node #(
	parameter int BIT_CYC = 32
) (
	// clock
	input  wire logic aclk,
	// device side of the transceiver
	input  wire logic txd,
	input  wire logic transmit_drive_control,
	output logic      rxd
);
	// ****************************************************************
	// bus and remote node
	// ****************************************************************
	logic [7:0] got[$];
	logic [7:0] sh;
	logic       line;
	// failsafe bias holds the bus high when undriven
	assign line = transmit_drive_control ? txd : 1'h1;
	initial rxd = 1'h1;
	// remote receiver, samples each bit in its middle
	initial begin
		forever begin
			@(posedge aclk);
			if (!line) begin
				repeat (BIT_CYC / 2) @(posedge aclk);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CYC) @(posedge aclk);
					sh[i] = line;
				end
				repeat (BIT_CYC) @(posedge aclk);
				if (line) got.push_back(sh);
			end
		end
	end
	// remote sender, 8n1 lsb first, ordinary reception path
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT_CYC) @(posedge aclk);
		end
	endtask
endmodule // rtu_node

// >>> tb_rs485_tx_direction_uart.sv
// self-checking bench for the rs485 uart top
`timescale 1ns/100ps
`include "rtu_defs.svh"
module tb_rs485_tx_direction_uart;
	// ****************************************************************
	// signals, design and node
	// ****************************************************************
	localparam logic [4:0] A_DATA = {`RTU_IDX_DATA, 2'h0};
	localparam logic [4:0] A_MCR = {`RTU_IDX_MODEM, 2'h0};
	localparam logic [4:0] A_LSR = {`RTU_IDX_LSR, 2'h0};
	localparam logic [4:0] A_DIV = {`RTU_IDX_DIV, 2'h0};
	localparam logic [4:0] A_IST = {`RTU_IDX_ISTAT, 2'h0};
	localparam logic [4:0] A_IMK = {`RTU_IDX_IMASK, 2'h0};
	localparam logic [1:0] OK = `RTU_RESP_OKAY;
	localparam logic [1:0] ERR = `RTU_RESP_SLVERR;
	logic        aclk, aresetn, txd, rxd, transmit_drive_control, irq;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          n_errors, samples_checked, cyc;
	rtu_top i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid_unused_tie(1'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .txd, .rxd, .transmit_drive_control, .irq);
	rtu_node #(.BIT_CYC(32)) i_node (.aclk, .txd, .transmit_drive_control, .rxd);
	always #2.5 aclk = ~aclk;
	// hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// one axi4-lite write, response compared
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				done = 1'h1;
				s_axi_bready <= 1'h0;
				chk("bresp", 32'(er), 32'(s_axi_bresp));
			end
		end
	endtask
	// one axi4-lite read into rd and rsp
	task automatic rdr(input logic [4:0] a);
		logic done;
		done = 1'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				done = 1'h1;
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'h0;
			end
		end
	endtask
	task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
		rdr(a);
		chk("rresp", 32'(OK), 32'(rsp));
		chk(nm, e, rd);
	endtask
	// poll line status until holding and shift are both empty
	task automatic drain();
		int k;
		k = 0;
		rdr(A_LSR);
		while (rd[6:5] !== 2'h0 && k < 400) begin
			rdr(A_LSR);
			k++;
		end
		chk("lsr drained", 32'h0, rd);
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rdc("mcr reset", A_MCR, 32'h0);
		chk("drive reset", 32'h0, 32'(transmit_drive_control));
		wr(A_DIV, 32'h1, OK);
		rdc("divider", A_DIV, 32'h1);
		rdr(5'h04);
		chk("unmapped", 32'(ERR), 32'(rsp));
		wr(A_LSR, 32'h0, ERR);
		rdc("lsr idle", A_LSR, 32'h0);
		wr(A_MCR, 32'h0, OK);
		repeat (1100) @(posedge aclk);
		wr(A_MCR, 32'h1, OK);
		chk("drive on", 32'h1, 32'(transmit_drive_control));
		wr(A_DATA, 32'ha5, OK);
		wr(A_DATA, 32'h3c, OK);
		rdc("lsr busy", A_LSR, 32'h60);
		drain();
		chk("node count", 32'h2, 32'(i_node.got.size()));
		chk("byte 0", 32'ha5, 32'(i_node.got[0]));
		chk("byte 1", 32'h3c, 32'(i_node.got[1]));
		wr(A_MCR, 32'h0, OK);
		chk("drive off", 32'h0, 32'(transmit_drive_control));
		chk("irq masked", 32'h0, 32'(irq));
		wr(A_IMK, 32'h2, OK);
		chk("irq on", 32'h1, 32'(irq));
		rdc("istat tx", A_IST, 32'h2);
		wr(A_IST, 32'h2, OK);
		chk("irq cleared", 32'h0, 32'(irq));
		wr(A_DATA, 32'h77, OK);
		drain();
		chk("bus undriven", 32'h2, 32'(i_node.got.size()));
		i_node.send_byte(8'h5e);
		rdc("lsr rx", A_LSR, 32'h01);
		rdc("rx data", A_DATA, 32'h5e);
		chk("drive idle rx", 32'h0, 32'(transmit_drive_control));
		rdc("istat rx", A_IST, 32'h3);
		give_verdict();
	end
endmodule // tb_rs485_tx_direction_uart
